//--- hw/ecl_consts.svh
`ifndef ECL_CONSTS_SVH
`define ECL_CONSTS_SVH
// Address space of the data EEPROM
`define ECL_ADDR_LO 11'h000
`define ECL_ADDR_HI 11'h7FF
`define ECL_ROW_MSB 10
`define ECL_ROW_LSB 7
`define ECL_COL_MSB 6
`define ECL_PAGE_BYTES 128
`define ECL_ROWS 16
// Control register values and bits
`define ECL_KEY1 8'h50
`define ECL_KEY2 8'hA0
`define ECL_CTL_SEL_BIT 1
`define ECL_CTL_BUSY_BIT 0
`define ECL_CTL_RESET 8'h00
// Program time per byte slot
`define ECL_PROG_NS 3200
`define ECL_CLK_NS 25
`define ECL_PROG_CYCLES 8'h80
`endif

//--- hw/ecl_eeprom_unit.sv
`timescale 1ns/1ps
`include "ecl_consts.svh"
// Operation
// - EEPROM occupies external-data addresses 0000h to 07FFh.
// - Accesses route to EEPROM only when the control select bit is set.
// - Selected reads return the EEPROM byte at the addressed location.
// - Writes load column latches first, then program one row.
// - One programming pass covers one to 128 bytes of a page.
// - Only bytes with a set marker are programmed; others stay unchanged.
// - Writing a column latch sets that byte's marker bit.
// - All marker bits clear once the row is fully programmed.
// - Latch loads come one byte per external-data write.
// - Pointer bits 10:7 select the row, bits 6:0 the byte.
// - Writing 50h then A0h to the control register starts programming.
// - Busy flag sets at start; EEPROM reads are blocked meanwhile.
// - Hardware clears the busy flag when programming ends.
// - Programming uses the most recently loaded page address.
module ecl_eeprom_unit (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clockEnable,
  input wire logic [15:0] pointerAddr,
  input wire logic [7:0] cpuWrData,
  input wire logic xdataRead,
  input wire logic xdataWrite,
  input wire logic ctlWrite,
  input wire logic ctlRead,
  output logic [7:0] cpuRdData,
  output logic cpuRdValid,
  output logic eepromSelected,
  output logic nvmProgramBusyFlag,
  output logic arrayWrite,
  output logic [10:0] arrayWrAddr,
  output logic [7:0] arrayWrData,
  output logic [10:0] arrayRdAddr,
  input wire logic [7:0] arrayRdData
);
  ecl_pkg::ecl_state_t stateQ, stateD;
  logic [7:0] ctlQ;
  logic keyArmedQ;
  logic [3:0] pageRowQ;
  logic [6:0] scanColQ;
  logic [7:0] slotCntQ;
  logic [7:0] cpuRdDataQ;
  logic cpuRdValidQ;
  logic [7:0] arrayWrDataQ;
  logic [10:0] arrayWrAddrQ;
  logic arrayWriteQ;
  logic [7:0] latchData;
  logic latchMark;

  ////////////////////////////////////////////////////////////////////
  // Address decode and access steering
  function automatic logic inEeprom(input logic [15:0] a);
    inEeprom = (a[15:11] == 5'h00);
  endfunction

  wire selBit = ctlQ[`ECL_CTL_SEL_BIT];
  wire busy = (stateQ != ecl_pkg::ECL_IDLE);
  wire hit = inEeprom(pointerAddr) && selBit;
  wire rdHit = hit && xdataRead && !busy;
  wire latchLoad = hit && xdataWrite && !busy;
  wire startProg = ctlWrite && keyArmedQ &&
    (cpuWrData == `ECL_KEY2) && !busy;
  wire slotEnd = (slotCntQ == `ECL_PROG_CYCLES - 8'h01);
  wire lastCol = (scanColQ == 7'h7F);
  wire rowDone = (stateQ == ecl_pkg::ECL_DONE);

  assign eepromSelected = hit;
  assign nvmProgramBusyFlag = busy;
  assign arrayRdAddr = pointerAddr[10:0];
  assign cpuRdData = cpuRdDataQ;
  assign cpuRdValid = cpuRdValidQ;
  assign arrayWrite = arrayWriteQ;
  assign arrayWrAddr = arrayWrAddrQ;
  assign arrayWrData = arrayWrDataQ;

  ecl_latch_bank uLatch (
    .clock(clock),
    .resetn(resetn),
    .clockEnable(clockEnable),
    .loadEn(latchLoad),
    .loadCol(pointerAddr[`ECL_COL_MSB:0]),
    .loadData(cpuWrData),
    .clearMarks(rowDone),
    .readCol(scanColQ),
    .readData(latchData),
    .readMark(latchMark)
  );

  ////////////////////////////////////////////////////////////////////
  // Programming sequencer: one slot per byte column of the row
  always_comb begin
    stateD = stateQ;
    case (stateQ)
      ecl_pkg::ECL_IDLE: begin
        if (startProg) begin
          stateD = ecl_pkg::ECL_PROG;
        end
      end
      ecl_pkg::ECL_PROG: begin
        if (slotEnd && lastCol) begin
          stateD = ecl_pkg::ECL_DONE;
        end
      end
      ecl_pkg::ECL_DONE: begin
        stateD = ecl_pkg::ECL_IDLE;
      end
      default: begin
        stateD = ecl_pkg::ECL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stateQ <= ecl_pkg::ECL_IDLE;
    end else if (clockEnable) begin
      stateQ <= stateD;
    end
  end

  // Control register and key arming; any other write disarms
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctlQ <= `ECL_CTL_RESET;
      keyArmedQ <= 1'b0;
    end else if (clockEnable) begin
      if (ctlWrite) begin
        ctlQ <= cpuWrData & 8'hFE;
        keyArmedQ <= (cpuWrData == `ECL_KEY1);
      end else if (xdataWrite || xdataRead) begin
        keyArmedQ <= 1'b0;
      end
    end
  end

  // Last loaded page wins as the row to program
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pageRowQ <= 4'h0;
    end else if (clockEnable && latchLoad) begin
      pageRowQ <= pointerAddr[`ECL_ROW_MSB:`ECL_ROW_LSB];
    end
  end

  // Column scan and slot timer
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scanColQ <= 7'h00;
      slotCntQ <= 8'h00;
    end else if (clockEnable) begin
      if (stateQ != ecl_pkg::ECL_PROG) begin
        scanColQ <= 7'h00;
        slotCntQ <= 8'h00;
      end else if (slotEnd) begin
        slotCntQ <= 8'h00;
        scanColQ <= scanColQ + 7'h01;
      end else begin
        slotCntQ <= slotCntQ + 8'h01;
      end
    end
  end

  // Array write strobe only for marked bytes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      arrayWriteQ <= 1'b0;
      arrayWrAddrQ <= 11'h000;
      arrayWrDataQ <= 8'h00;
    end else if (clockEnable) begin
      arrayWriteQ <= (stateQ == ecl_pkg::ECL_PROG) && slotEnd &&
        latchMark;
      arrayWrAddrQ <= {pageRowQ, scanColQ};
      arrayWrDataQ <= latchData;
    end
  end

  // Read data return, control read shows busy and select
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cpuRdDataQ <= 8'h00;
      cpuRdValidQ <= 1'b0;
    end else if (clockEnable) begin
      cpuRdValidQ <= rdHit || ctlRead;
      if (ctlRead) begin
        cpuRdDataQ <= {ctlQ[7:1], busy};
      end else if (rdHit) begin
        cpuRdDataQ <= arrayRdData;
      end
    end
  end

  AST_NO_READ_BUSY: assert property (@(posedge clock) disable iff (!resetn)
    busy && xdataRead && !ctlRead |=> !cpuRdValid)
    else $error("EEPROM read served while busy");
  AST_START: assert property (@(posedge clock) disable iff (!resetn)
    clockEnable && startProg |=> nvmProgramBusyFlag)
    else $error("key pair did not start programming");
  AST_NOSEL: assert property (@(posedge clock) disable iff (!resetn)
    !selBit |-> !eepromSelected)
    else $error("EEPROM selected without select bit");
  AST_ROWADDR: assert property (@(posedge clock) disable iff (!resetn)
    arrayWrite |-> arrayWrAddr[10:7] == pageRowQ)
    else $error("array write outside latched page");
  AST_END: assert property (@(posedge clock) disable iff (!resetn)
    clockEnable && rowDone |=> !nvmProgramBusyFlag)
    else $error("busy not cleared after row");
  AST_CLR: assert property (@(posedge clock) disable iff (!resetn)
    clockEnable && rowDone && !latchLoad |=> uLatch.markQ == '0)
    else $error("markers not cleared after row");
  // Array strobes only come from the programming sequence
  AST_WR_BUSY: assert property (@(posedge clock) disable iff (!resetn)
    arrayWrite |-> nvmProgramBusyFlag)
    else $error("array written outside programming");
  AST_RANGE: assert property (@(posedge clock) disable iff (!resetn)
    pointerAddr[15:11] != 5'h00 |-> !eepromSelected)
    else $error("select outside EEPROM range");
  AST_MARKONLY: assert property (@(posedge clock) disable iff (!resetn)
    arrayWrite |-> $past(latchMark))
    else $error("unmarked byte programmed");
endmodule

//--- hw/ecl_latch_bank.sv
`timescale 1ns/1ps
`include "ecl_consts.svh"
module ecl_latch_bank (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clockEnable,
  input wire logic loadEn,
  input wire logic [6:0] loadCol,
  input wire logic [7:0] loadData,
  input wire logic clearMarks,
  input wire logic [6:0] readCol,
  output logic [7:0] readData,
  output logic readMark
);
  logic [7:0] dataQ [0:`ECL_PAGE_BYTES-1];
  logic [`ECL_PAGE_BYTES-1:0] markQ;

  ////////////////////////////////////////////////////////////////////
  // Column data latches, no reset needed on data
  always_ff @(posedge clock) begin
    if (clockEnable && loadEn) begin
      dataQ[loadCol] <= loadData;
    end
  end

  // Written-marker ninth bits; a load wins over a row clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      markQ <= '0;
    end else if (clockEnable) begin
      if (clearMarks) begin
        markQ <= '0;
      end
      if (loadEn) begin
        markQ[loadCol] <= 1'b1;
      end
    end
  end

  assign readData = dataQ[readCol];
  assign readMark = markQ[readCol];

  AST_MARK_SET: assert property (@(posedge clock) disable iff (!resetn)
    clockEnable && loadEn |=> markQ[$past(loadCol)])
    else $error("marker bit not set after latch load");
endmodule

//--- hw/ecl_pkg.sv
package ecl_pkg;
  typedef enum logic [1:0] {
    ECL_IDLE,
    ECL_PROG,
    ECL_DONE
  } ecl_state_t;
endpackage

//--- tb/ecl_array_model.sv
`timescale 1ns/1ps
// EEPROM array: same-cycle reads, one byte per write pulse
module ecl_array_model (
  input wire logic clock,
  input wire logic arrayWrite,
  input wire logic [10:0] arrayWrAddr,
  input wire logic [7:0] arrayWrData,
  input wire logic [10:0] arrayRdAddr,
  output logic [7:0] arrayRdData
);
  logic [7:0] mem [0:2047];
  // Known pattern so untouched bytes can be predicted
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
  end
  // Byte programming
  always @(posedge clock) begin
    if (arrayWrite) begin
      mem[arrayWrAddr] <= arrayWrData;
    end
  end
  assign arrayRdData = mem[arrayRdAddr];
endmodule

//--- tb/ecl_eeprom_unit_test.sv
`timescale 1ns/1ps
module ecl_eeprom_unit_test;
  localparam logic [3:0] XR = 4'h8;
  localparam logic [3:0] XW = 4'h4;
  localparam logic [3:0] CW = 4'h2;
  localparam logic [3:0] CR = 4'h1;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic xdataRead = 1'b0;
  logic xdataWrite = 1'b0;
  logic ctlWrite = 1'b0;
  logic ctlRead = 1'b0;
  logic clockEnable = 1'b1;
  logic [15:0] pointerAddr = 16'h0000;
  logic [7:0] cpuWrData = 8'h00;
  logic [7:0] cpuRdData, arrayWrData, arrayRdData;
  logic [10:0] arrayWrAddr, arrayRdAddr;
  logic cpuRdValid, eepromSelected, nvmProgramBusyFlag, arrayWrite;
  int fails = 0;
  int totalChecks = 0;
  int wrCount = 0;
  // Clock
  always #12.5 clock = ~clock;
  // Count array write strobes seen at the far side
  always @(posedge clock) begin
    if (arrayWrite === 1'b1) begin
      wrCount++;
    end
  end
  ecl_eeprom_unit u_ecl_eeprom_unit (.clock(clock), .resetn(resetn),
    .clockEnable(clockEnable), .pointerAddr(pointerAddr),
    .cpuWrData(cpuWrData),
    .xdataRead(xdataRead), .xdataWrite(xdataWrite), .ctlWrite(ctlWrite),
    .ctlRead(ctlRead), .cpuRdData(cpuRdData), .cpuRdValid(cpuRdValid),
    .eepromSelected(eepromSelected),
    .nvmProgramBusyFlag(nvmProgramBusyFlag), .arrayWrite(arrayWrite),
    .arrayWrAddr(arrayWrAddr), .arrayWrData(arrayWrData),
    .arrayRdAddr(arrayRdAddr), .arrayRdData(arrayRdData));
  ecl_array_model u_ecl_array_model (.clock(clock),
    .arrayWrite(arrayWrite), .arrayWrAddr(arrayWrAddr),
    .arrayWrData(arrayWrData), .arrayRdAddr(arrayRdAddr),
    .arrayRdData(arrayRdData));
  ////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic checkBit(input logic got, input logic exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] initVal(input logic [10:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Bus cycles, entered and left just after a rising edge
  task automatic drive(input logic [3:0] k, input logic [15:0] a,
                       input logic [7:0] d);
    {xdataRead, xdataWrite, ctlWrite, ctlRead} = k;
    pointerAddr = a;
    cpuWrData = d;
    @(posedge clock);
    #2;
  endtask
  task automatic idle;
    {xdataRead, xdataWrite, ctlWrite, ctlRead} = 4'h0;
    @(posedge clock);
    #2;
  endtask
  task automatic rd(input logic [3:0] k, input logic [15:0] a,
                    input logic [7:0] exp, input logic hit);
    logic seen;
    seen = 1'b0;
    drive(k, a, 8'h00);
    {xdataRead, xdataWrite, ctlWrite, ctlRead} = 4'h0;
    for (int i = 0; i < 3; i++) begin
      if (!seen && cpuRdValid === 1'b1) begin
        seen = 1'b1;
        check8(cpuRdData, exp);
      end
      @(posedge clock);
      #2;
    end
    checkBit(seen, hit);
  endtask
  task automatic waitBusy(input logic level, input int bound);
    int n;
    n = 0;
    while (nvmProgramBusyFlag !== level && n < bound) begin
      @(posedge clock);
      #2;
      n++;
    end
    if (nvmProgramBusyFlag !== level) begin
      fails++;
      $display("mismatch at %0t: busy wait ran out", $time);
      finish_test();
    end
  endtask
  // Key pair, optionally broken by a read in between
  task automatic launch(input logic abort);
    drive(CW, 16'h0000, 8'h50);
    if (abort) begin
      drive(XR, 16'h0001, 8'h00);
    end
    drive(CW, 16'h0000, 8'hA0);
    idle();
    if (abort) begin
      idle();
      checkBit(nvmProgramBusyFlag, 1'b0);
      drive(CW, 16'h0000, 8'h02);
      idle();
    end else begin
      waitBusy(1'b1, 4);
      drive(CW, 16'h0000, 8'h02);
      idle();
      rd(CR, 16'h0000, 8'h03, 1'b1);
      rd(XR, 16'h0280, 8'h00, 1'b0);
      waitBusy(1'b0, 17000);
      rd(CR, 16'h0000, 8'h02, 1'b1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_select;
    checkBit(nvmProgramBusyFlag, 1'b0);
    rd(XR, 16'h0010, 8'h00, 1'b0);
    drive(CW, 16'h0000, 8'h02);
    idle();
    rd(CR, 16'h0000, 8'h02, 1'b1);
    clockEnable = 1'b0;
    rd(CR, 16'h0000, 8'h00, 1'b0);
    clockEnable = 1'b1;
    rd(XR, 16'h0010, initVal(11'h010), 1'b1);
    rd(XR, 16'h07FF, initVal(11'h7FF), 1'b1);
    checkBit(eepromSelected, 1'b1);
    rd(XR, 16'h0800, 8'h00, 1'b0);
    checkBit(eepromSelected, 1'b0);
    $display("test_select done");
  endtask
  task automatic test_program;
    drive(XW, 16'h0180, 8'h11);
    drive(XW, 16'h01FF, 8'h22);
    drive(XW, 16'h0285, 8'h33);
    idle();
    launch(1'b0);
    check8(8'(wrCount), 8'h03);
    rd(XR, 16'h0280, 8'h11, 1'b1);
    rd(XR, 16'h02FF, 8'h22, 1'b1);
    rd(XR, 16'h0285, 8'h33, 1'b1);
    rd(XR, 16'h0281, initVal(11'h281), 1'b1);
    rd(XR, 16'h0180, initVal(11'h180), 1'b1);
    $display("test_program done");
  endtask
  task automatic test_markers;
    launch(1'b1);
    drive(XW, 16'h0109, 8'h44);
    idle();
    launch(1'b0);
    check8(8'(wrCount), 8'h04);
    rd(XR, 16'h0109, 8'h44, 1'b1);
    rd(XR, 16'h0100, initVal(11'h100), 1'b1);
    rd(XR, 16'h017F, initVal(11'h17F), 1'b1);
    $display("test_markers done");
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    #2;
    resetn = 1'b1;
    @(posedge clock);
    #2;
    test_select();
    test_program();
    test_markers();
    finish_test();
  end
endmodule
